// [include/ccr_pkg.sv]
`default_nettype none
package ccr_pkg;
  // Register offsets (word index on the plain register port)
  localparam logic [4:0] REG_COPPER_CONTROL = 5'h00;
  localparam logic [4:0] REG_LINE_CTRL      = 5'h10;
  localparam logic [4:0] REG_MAC_CTRL       = 5'h11;
  localparam logic [4:0] REG_STATE          = 5'h12;

  // Copper control field positions
  localparam int BIT_RESET    = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPD_LSB  = 13;
  localparam int BIT_AN_EN    = 12;
  localparam int BIT_PWR_DN   = 11;
  localparam int BIT_ISOLATE  = 10;
  localparam int BIT_AN_RST   = 9;
  localparam int BIT_DUPLEX   = 8;
  localparam int BIT_SPD_MSB  = 6;

  // Line control: second power-down bit
  localparam int BIT_LINE_PDN = 2;
  // MAC control: keep MAC interface alive in power down, loopback speed
  localparam int BIT_MAC_KEEP  = 3;
  localparam int BIT_LB_SPD_MSB = 6;
  localparam int BIT_LB_SPD_LSB = 13;

  // Reset values and copper control write mask
  localparam logic [15:0] COPPER_CONTROL_RST = 16'h1140;
  localparam logic [15:0] LINE_CTRL_RST      = 16'h0000;
  localparam logic [15:0] MAC_CTRL_RST       = 16'h0040;
  localparam logic [15:0] COPPER_WMASK       = 16'hFF40;

  // Length of the state-machine reset pulse
  localparam int RESET_TIME_NS   = 80;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RESET_CYCLES    =
    (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RESET_CYC = 4'(RESET_CYCLES);

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10,
    SPD_RSVD = 2'b11
  } ccr_speed_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RESET = 2'b01,
    ST_PDOWN = 2'b10
  } ccr_state_t;

  typedef struct packed {
    logic [15:0] copper;
    logic [15:0] line;
    logic [15:0] mac;
    logic [1:0]  spd;
    logic        an_en;
    logic        duplex;
    ccr_state_t  st;
    logic [3:0]  cnt;
    logic        an_restart;
    logic [15:0] rdata;
  } ccr_regs_t;

  typedef struct packed {
    logic [1:0] speed;
    logic       full_duplex;
    logic       an_enable;
    logic       adv_only_1000;
  } ccr_link_cfg_t;
endpackage
`default_nettype wire

// [rtl/ccr_copper_control.sv]
`default_nettype none
module ccr_copper_control (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  // Register port
  input  wire logic [4:0]            ADDR_I,
  input  wire logic [15:0]           WDATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic      [15:0]           RDATA_O,
  // MAC-side data
  input  wire logic [7:0]            MAC_TXD_I,
  input  wire logic                  MAC_TXEN_I,
  output logic      [7:0]            MAC_RXD_O,
  output logic                       MAC_RXDV_O,
  output logic                       MAC_OE_O,
  // Line side
  input  wire logic [7:0]            LINE_RXD_I,
  input  wire logic                  LINE_RXDV_I,
  input  wire logic                  LINE_LINK_I,
  output logic      [7:0]            LINE_TXD_O,
  output logic                       LINE_TXEN_O,
  output logic                       LINK_UP_O,
  // Controls to other PHY logic
  output logic                       SM_RESET_O,
  output logic                       AN_RESTART_O,
  output logic                       LOOPBACK_O,
  output logic                       POWER_DOWN_O,
  output logic                       MAC_IF_ON_O,
  output ccr_pkg::ccr_link_cfg_t     LINK_CFG_O
);

  ccr_pkg::ccr_regs_t r_reg;
  ccr_pkg::ccr_regs_t r_next;

  logic [7:0] txd_reg;
  logic       txen_reg;
  logic [7:0] rxd_reg;
  logic       rxdv_reg;

  logic wr_copper;
  logic pd_req;
  logic pd_exit;
  logic apply;
  logic sw_reset;

  assign wr_copper = WR_I && (ADDR_I == ccr_pkg::REG_COPPER_CONTROL);

  always_comb begin
    r_next     = r_reg;
    r_next.an_restart = 1'b0;
    sw_reset   = 1'b0;
    pd_req     = r_reg.copper[ccr_pkg::BIT_PWR_DN]
                 | r_reg.line[ccr_pkg::BIT_LINE_PDN];
    pd_exit    = (r_reg.st == ccr_pkg::ST_PDOWN) && !pd_req;
    apply      = 1'b0;
    if (wr_copper) begin
      r_next.copper = (WDATA_I & ccr_pkg::COPPER_WMASK)
                      | (r_reg.copper & 16'h8000);
      if (WDATA_I[ccr_pkg::BIT_RESET]) begin
        sw_reset = 1'b1;
      end
      if (WDATA_I[ccr_pkg::BIT_AN_RST]) begin
        apply = 1'b1;
        r_next.an_restart = 1'b1;
      end
    end
    if (WR_I && ADDR_I == ccr_pkg::REG_LINE_CTRL) begin
      r_next.line = WDATA_I & 16'h0004;
    end
    if (WR_I && ADDR_I == ccr_pkg::REG_MAC_CTRL) begin
      r_next.mac = WDATA_I & 16'h2048;
    end
    if (pd_exit) begin
      sw_reset = 1'b1;
    end
    if (sw_reset) begin
      apply = 1'b1;
      r_next.an_restart = 1'b1;
      r_next.copper[ccr_pkg::BIT_RESET] = 1'b1;
      r_next.st = ccr_pkg::ST_RESET;
      r_next.cnt = ccr_pkg::RESET_CYC;
    end
    if (apply) begin
      // Pending values latch from the copper word as it stands this cycle, the written one or the held one on power-up
      r_next.spd = {r_next.copper[ccr_pkg::BIT_SPD_MSB],
                    r_next.copper[ccr_pkg::BIT_SPD_LSB]};
      r_next.an_en = r_next.copper[ccr_pkg::BIT_AN_EN];
      r_next.duplex = r_next.copper[ccr_pkg::BIT_DUPLEX];
    end
    case (r_reg.st)
      ccr_pkg::ST_IDLE: begin
        if (pd_req && !sw_reset) begin
          r_next.st = ccr_pkg::ST_PDOWN;
        end
      end
      ccr_pkg::ST_RESET: begin
        if (!sw_reset) begin
          if (r_reg.cnt <= 4'h1) begin
            r_next.cnt = 4'h0;
            r_next.copper[ccr_pkg::BIT_RESET] = 1'b0;
            r_next.st = pd_req ? ccr_pkg::ST_PDOWN : ccr_pkg::ST_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt - 4'h1;
          end
        end
      end
      ccr_pkg::ST_PDOWN: begin
      end
      default: begin
        r_next.st = ccr_pkg::ST_IDLE;
      end
    endcase
    // Restart bit reads back as zero: self-clearing
    r_next.copper[ccr_pkg::BIT_AN_RST] = 1'b0;
    r_next.rdata = r_reg.rdata;
    if (RD_I) begin
      case (ADDR_I)
        ccr_pkg::REG_COPPER_CONTROL: r_next.rdata = r_reg.copper;
        ccr_pkg::REG_LINE_CTRL:      r_next.rdata = r_reg.line;
        ccr_pkg::REG_MAC_CTRL:       r_next.rdata = r_reg.mac;
        ccr_pkg::REG_STATE: begin
          r_next.rdata = {10'h000, r_reg.st, r_reg.spd,
                          r_reg.an_en, r_reg.duplex};
        end
        default:                     r_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg.copper     <= ccr_pkg::COPPER_CONTROL_RST;
      r_reg.line       <= ccr_pkg::LINE_CTRL_RST;
      r_reg.mac        <= ccr_pkg::MAC_CTRL_RST;
      r_reg.spd        <= ccr_pkg::SPD_1000;
      r_reg.an_en      <= 1'b1;
      r_reg.duplex     <= 1'b1;
      r_reg.st         <= ccr_pkg::ST_IDLE;
      r_reg.cnt        <= 4'h0;
      r_reg.an_restart <= 1'b1;
      r_reg.rdata      <= 16'h0000;
    end else begin
      r_reg <= r_next;
    end
  end

  // Data path: loopback and isolate
  logic powered;
  logic mac_on;
  logic lb;
  assign powered = (r_reg.st != ccr_pkg::ST_PDOWN) && !pd_req;
  assign mac_on  = powered || r_reg.mac[ccr_pkg::BIT_MAC_KEEP];
  assign lb      = r_reg.copper[ccr_pkg::BIT_LOOPBACK];

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      txd_reg  <= 8'h00;
      txen_reg <= 1'b0;
      rxd_reg  <= 8'h00;
      rxdv_reg <= 1'b0;
    end else begin
      txen_reg <= 1'b0;
      rxdv_reg <= 1'b0;
      if (!r_reg.copper[ccr_pkg::BIT_ISOLATE] && mac_on) begin
        if (lb) begin
          rxd_reg  <= MAC_TXD_I;
          rxdv_reg <= MAC_TXEN_I;
        end else if (powered) begin
          txd_reg  <= MAC_TXD_I;
          txen_reg <= MAC_TXEN_I;
          rxd_reg  <= LINE_RXD_I;
          rxdv_reg <= LINE_RXDV_I;
        end
      end
    end
  end

  logic forced_gig;
  assign forced_gig = !r_reg.an_en && (r_reg.spd == ccr_pkg::SPD_1000);

  assign RDATA_O      = r_reg.rdata;
  assign MAC_RXD_O    = rxd_reg;
  assign MAC_RXDV_O   = rxdv_reg;
  assign MAC_OE_O     = mac_on && !r_reg.copper[ccr_pkg::BIT_ISOLATE];
  assign LINE_TXD_O   = txd_reg;
  assign LINE_TXEN_O  = txen_reg && !lb;
  assign LINK_UP_O    = LINE_LINK_I && !lb && powered;
  assign SM_RESET_O   = (r_reg.st == ccr_pkg::ST_RESET);
  assign AN_RESTART_O = r_reg.an_restart;
  assign LOOPBACK_O   = lb;
  assign POWER_DOWN_O = !powered;
  assign MAC_IF_ON_O  = mac_on;
  always_comb begin
    LINK_CFG_O.speed = lb ? {r_reg.mac[ccr_pkg::BIT_LB_SPD_MSB],
                             r_reg.mac[ccr_pkg::BIT_LB_SPD_LSB]}
                          : r_reg.spd;
    LINK_CFG_O.full_duplex   = r_reg.duplex;
    LINK_CFG_O.an_enable     = r_reg.an_en || forced_gig;
    LINK_CFG_O.adv_only_1000 = forced_gig;
  end

  // Assertions
  chk_reset_start: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_copper && WDATA_I[ccr_pkg::BIT_RESET] |=> SM_RESET_O
      && r_reg.copper[ccr_pkg::BIT_RESET] && AN_RESTART_O)
    else $error("Software reset did not start");
  chk_reset_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(SM_RESET_O) |-> !r_reg.copper[ccr_pkg::BIT_RESET])
    else $error("Reset bit not cleared with pulse end");
  chk_reset_bound: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(SM_RESET_O) |-> ##[1:12] !SM_RESET_O || sw_reset)
    else $error("Reset pulse too long");
  chk_loop_data: assert property (@(posedge CLK_I) disable iff (RST_I)
    lb && MAC_OE_O && $stable(lb) |=> MAC_RXD_O == $past(MAC_TXD_I))
    else $error("Loopback data not returned");
  chk_loop_link: assert property (@(posedge CLK_I) disable iff (RST_I)
    lb |-> !LINK_UP_O && !LINE_TXEN_O)
    else $error("Link up during loopback");
  chk_speed_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !apply |=> $stable(r_reg.spd) && $stable(r_reg.an_en))
    else $error("Speed changed without trigger");
  chk_forced_gig: assert property (@(posedge CLK_I) disable iff (RST_I)
    forced_gig |-> LINK_CFG_O.an_enable && LINK_CFG_O.adv_only_1000)
    else $error("Forced gigabit lost negotiation");
  chk_pd_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    POWER_DOWN_O && pd_req |=> POWER_DOWN_O)
    else $error("Left power down early");
  chk_pd_exit: assert property (@(posedge CLK_I) disable iff (RST_I)
    pd_exit |=> SM_RESET_O && AN_RESTART_O)
    else $error("No reset on power-up");
  chk_mac_keep: assert property (@(posedge CLK_I) disable iff (RST_I)
    POWER_DOWN_O |-> MAC_IF_ON_O == r_reg.mac[ccr_pkg::BIT_MAC_KEEP])
    else $error("MAC interface power wrong");
  chk_an_restart: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_copper && WDATA_I[ccr_pkg::BIT_AN_RST] |=> AN_RESTART_O
      ##1 !r_reg.copper[ccr_pkg::BIT_AN_RST])
    else $error("Restart not issued");
  chk_isolate: assert property (@(posedge CLK_I) disable iff (RST_I)
    r_reg.copper[ccr_pkg::BIT_ISOLATE] |-> !MAC_OE_O ##1 !MAC_RXDV_O)
    else $error("Isolate not applied");

  // Software reset pulse, step by step
  sequence s_reset_kick;
    wr_copper && WDATA_I[ccr_pkg::BIT_RESET];
  endsequence

  sequence s_reset_quiet;
    (!sw_reset) [*8] ##1 !sw_reset ##1 !sw_reset;
  endsequence

  property p_reset_hold;
    @(posedge CLK_I) disable iff (RST_I)
      s_reset_kick |=> SM_RESET_O [*8];
  endproperty

  property p_reset_end;
    @(posedge CLK_I) disable iff (RST_I)
      s_reset_kick ##1 s_reset_quiet
        |=> !SM_RESET_O && !r_reg.copper[ccr_pkg::BIT_RESET];
  endproperty

  chk_reset_hold: assert property (p_reset_hold)
    else $error("Reset pulse ended early");
  chk_reset_end: assert property (p_reset_end)
    else $error("Reset pulse did not end on time");

  // Deferred configuration and restart pulse
  chk_apply_cfg: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_copper && WDATA_I[ccr_pkg::BIT_AN_RST]
      |=> r_reg.spd == {r_reg.copper[ccr_pkg::BIT_SPD_MSB],
                        r_reg.copper[ccr_pkg::BIT_SPD_LSB]}
      && r_reg.an_en == r_reg.copper[ccr_pkg::BIT_AN_EN])
    else $error("Restart did not apply held settings");
  chk_an_once: assert property (@(posedge CLK_I) disable iff (RST_I)
    !sw_reset && !(wr_copper && WDATA_I[ccr_pkg::BIT_AN_RST])
      |=> !AN_RESTART_O)
    else $error("Restart pulse without trigger");
  chk_dup_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !apply |=> $stable(r_reg.duplex))
    else $error("Duplex changed without trigger");
  chk_cfg_dup: assert property (@(posedge CLK_I) disable iff (RST_I)
    LINK_CFG_O.full_duplex == r_reg.duplex)
    else $error("Duplex output differs from applied value");

  // Power down
  chk_pd_enter: assert property (@(posedge CLK_I) disable iff (RST_I)
    r_reg.st == ccr_pkg::ST_IDLE && pd_req && !sw_reset
      |=> r_reg.st == ccr_pkg::ST_PDOWN)
    else $error("Power down not entered");
  chk_pd_level: assert property (@(posedge CLK_I) disable iff (RST_I)
    pd_req |-> POWER_DOWN_O)
    else $error("Powered while a power-down bit is set");
  chk_pd_after: assert property (@(posedge CLK_I) disable iff (RST_I)
    r_reg.st == ccr_pkg::ST_RESET && r_reg.cnt <= 4'h1 && pd_req
      && !sw_reset |=> r_reg.st == ccr_pkg::ST_PDOWN)
    else $error("Reset pulse left power down");
  chk_pd_link: assert property (@(posedge CLK_I) disable iff (RST_I)
    POWER_DOWN_O |-> !LINK_UP_O)
    else $error("Link up in power down");
  chk_mac_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    POWER_DOWN_O && !r_reg.mac[ccr_pkg::BIT_MAC_KEEP]
      |-> !MAC_OE_O)
    else $error("MAC interface driven in power down");

  // Data path and register port
  chk_lb_speed: assert property (@(posedge CLK_I) disable iff (RST_I)
    lb |-> LINK_CFG_O.speed == {r_reg.mac[ccr_pkg::BIT_LB_SPD_MSB],
                                r_reg.mac[ccr_pkg::BIT_LB_SPD_LSB]})
    else $error("Loopback speed not from MAC control");
  chk_tx_block: assert property (@(posedge CLK_I) disable iff (RST_I)
    !MAC_OE_O |=> !LINE_TXEN_O)
    else $error("Transmit input passed while isolated");
  chk_rd_copper: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == ccr_pkg::REG_COPPER_CONTROL
      |=> RDATA_O == $past(r_reg.copper))
    else $error("Copper control read wrong");
  chk_rd_line: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I == ccr_pkg::REG_LINE_CTRL
      |=> RDATA_O == $past(r_reg.line))
    else $error("Line control read wrong");
  chk_rd_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RD_I |=> $stable(RDATA_O))
    else $error("Read data changed without a read");
  chk_rd_none: assert property (@(posedge CLK_I) disable iff (RST_I)
    RD_I && ADDR_I > ccr_pkg::REG_STATE |=> RDATA_O == 16'h0000)
    else $error("Unmapped read not zero");

endmodule
`default_nettype wire

// [verif/ccr_mac_model.sv]
`default_nettype none
module ccr_mac_model (
  // Clock
  input  wire logic       clk_i,
  // MAC transmit side
  output logic      [7:0] txd_o,
  output logic            txen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'h3D64;
  initial begin
    txd_o  = 8'h00;
    txen_o = 1'b0;
  end
  // A new random byte every cycle, so a stale echo matches only if a byte repeats
  always @(posedge clk_i) begin
    txd_o  <= 8'($random(seed));
    txen_o <= 1'b1;
  end
endmodule
`default_nettype wire

// [verif/copper_phy_control_register_bench.sv]
`default_nettype none
module copper_phy_control_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   CLK_I       = 1'b0;
  logic                   RST_I       = 1'b1;
  logic [4:0]             ADDR_I      = 5'h00;
  logic [15:0]            WDATA_I     = 16'h0000;
  logic                   WR_I        = 1'b0;
  logic                   RD_I        = 1'b0;
  logic                   LINE_LINK_I = 1'b1;
  logic [15:0]            RDATA_O, d;
  logic [7:0]             MAC_TXD_I, MAC_RXD_O, LINE_TXD_O, x;
  logic                   MAC_TXEN_I, MAC_RXDV_O, MAC_OE_O, LINE_TXEN_O;
  logic                   LINK_UP_O, SM_RESET_O, AN_RESTART_O;
  logic                   LOOPBACK_O, POWER_DOWN_O, MAC_IF_ON_O;
  ccr_pkg::ccr_link_cfg_t LINK_CFG_O;
  int                     fails       = 0;
  int                     comparisons = 0;

  ccr_copper_control u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .MAC_TXD_I(MAC_TXD_I), .MAC_TXEN_I(MAC_TXEN_I), .MAC_RXD_O(MAC_RXD_O),
    .MAC_RXDV_O(MAC_RXDV_O), .MAC_OE_O(MAC_OE_O), .LINE_RXD_I(8'h00),
    .LINE_RXDV_I(1'b0), .LINE_LINK_I(LINE_LINK_I), .LINE_TXD_O(LINE_TXD_O),
    .LINE_TXEN_O(LINE_TXEN_O), .LINK_UP_O(LINK_UP_O),
    .SM_RESET_O(SM_RESET_O), .AN_RESTART_O(AN_RESTART_O),
    .LOOPBACK_O(LOOPBACK_O), .POWER_DOWN_O(POWER_DOWN_O),
    .MAC_IF_ON_O(MAC_IF_ON_O), .LINK_CFG_O(LINK_CFG_O));
  ccr_mac_model u_mac (.clk_i(CLK_I), .txd_o(MAC_TXD_I),
    .txen_o(MAC_TXEN_I));

  initial begin
    forever #4 CLK_I = ~CLK_I;
  end

  task automatic check(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic conclude();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge CLK_I);
    ADDR_I  <= a;
    WDATA_I <= v;
    WR_I    <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 d = RDATA_O;
  endtask

  task automatic wait_sm(input logic v);
    for (int i = 0; i < 20 && SM_RESET_O !== v; i++) begin
      @(posedge CLK_I);
      #1;
    end
  endtask

  // Copper word for a speed code with restart set, AN and duplex off
  function automatic logic [15:0] spd_word(input logic [1:0] s);
    spd_word = 16'h0200 | (16'(s[0]) << 13) | (16'(s[1]) << 6);
  endfunction

  // Applied-state word: {state, speed, an_en, duplex}
  function automatic logic [15:0] st_word(input logic [1:0] s,
                                          input logic a, input logic u);
    st_word = {10'h000, 2'b00, s, a, u};
  endfunction

  initial begin
    repeat (5000) @(posedge CLK_I);
    fails++;
    conclude();
  end

  initial begin
    @(posedge CLK_I);
    #1 check("an_restart_in_reset", 16'(AN_RESTART_O), 16'h0001);
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd(ccr_pkg::REG_COPPER_CONTROL);
    check("copper_rst", d, ccr_pkg::COPPER_CONTROL_RST);
    rd(ccr_pkg::REG_STATE);
    check("state_rst", d, st_word(2'b10, 1'b1, 1'b1));
    wr(5'h05, 16'hFFFF);
    rd(5'h05);
    check("unmapped", d, 16'h0000);
    // Held write: stored but not applied
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h2000);
    check("held_speed", 16'(LINK_CFG_O.speed), 16'h0002);
    rd(ccr_pkg::REG_COPPER_CONTROL);
    check("held_word", d, 16'h2000);
    for (int s = 0; s < 3; s++) begin
      wr(ccr_pkg::REG_COPPER_CONTROL, spd_word(2'(s)));
      check("restart_pulse", 16'(AN_RESTART_O), 16'h0001);
      check("speed", 16'(LINK_CFG_O.speed), 16'(s));
      rd(ccr_pkg::REG_STATE);
      check("state", d, st_word(2'(s), 1'b0, 1'b0));
      rd(ccr_pkg::REG_COPPER_CONTROL);
      check("restart_clear", d, spd_word(2'(s)) & 16'hFDFF);
    end
    check("adv_only", 16'(LINK_CFG_O.adv_only_1000), 16'h0001);
    // Software reset
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h9140);
    check("sm_reset", 16'(SM_RESET_O), 16'h0001);
    check("reset_restart", 16'(AN_RESTART_O), 16'h0001);
    rd(ccr_pkg::REG_COPPER_CONTROL);
    check("reset_busy", d & 16'h8000, 16'h8000);
    repeat (7) @(posedge CLK_I);
    #1 check("sm_hold", 16'(SM_RESET_O), 16'h0001);
    @(posedge CLK_I);
    #1 check("sm_end", 16'(SM_RESET_O), 16'h0000);
    rd(ccr_pkg::REG_COPPER_CONTROL);
    check("reset_done", d & 16'h8000, 16'h0000);
    // Loopback with random MAC data
    wr(ccr_pkg::REG_MAC_CTRL, 16'h2000);
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h5140);
    check("loopback", 16'(LOOPBACK_O), 16'h0001);
    check("lb_speed", 16'(LINK_CFG_O.speed), 16'h0001);
    check("link_down", 16'(LINK_UP_O), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_I);
      #1 x = MAC_TXD_I;
      @(posedge CLK_I);
      #1 check("echo", {8'h00, MAC_RXD_O}, {8'h00, x});
      check("line_tx_off", 16'(LINE_TXEN_O), 16'h0000);
    end
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h1140);
    check("link_up", 16'(LINK_UP_O), 16'h0001);
    x = MAC_TXD_I;
    @(posedge CLK_I);
    #1 check("line_txd", {8'h00, LINE_TXD_O}, {8'h00, x});
    check("line_txen", 16'(LINE_TXEN_O), 16'h0001);
    // Isolate
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h1540);
    check("isolate", 16'(MAC_OE_O), 16'h0000);
    @(posedge CLK_I);
    #1 check("iso_txen", 16'(LINE_TXEN_O), 16'h0000);
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h1140);
    check("isolate_off", 16'(MAC_OE_O), 16'h0001);
    // Power down from both controls
    wr(ccr_pkg::REG_LINE_CTRL, 16'h0004);
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h1940);
    check("pdown", 16'(POWER_DOWN_O), 16'h0001);
    check("mac_off", 16'(MAC_IF_ON_O), 16'h0000);
    wr(ccr_pkg::REG_MAC_CTRL, 16'h0048);
    check("mac_keep", 16'(MAC_IF_ON_O), 16'h0001);
    wr(ccr_pkg::REG_COPPER_CONTROL, 16'h1140);
    check("pdown_held", 16'(POWER_DOWN_O), 16'h0001);
    wr(ccr_pkg::REG_LINE_CTRL, 16'h0000);
    wait_sm(1'b1);
    check("pup_reset", 16'(SM_RESET_O), 16'h0001);
    check("pup_on", 16'(POWER_DOWN_O), 16'h0000);
    wait_sm(1'b0);
    check("pup_done", 16'(SM_RESET_O), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
